// >>> beam_io_params.svh
/*
 * Beam and entry limits, reset values and timing figures.
 * Assumes a 10 MHz clock; included by its bare name.
 */
`ifndef BEAM_IO_PARAMS_SVH
`define BEAM_IO_PARAMS_SVH

// Geometry
`define NUM_PINS        4
`define PIN_IDX_W       2
`define NUM_BEAMS       1774
`define BEAM_W          11
`define BEAM_MAX        11'h6EE
`define BEAM_MIN        11'h001

// Configuration limits
`define ENTRY_W         9
`define FD_MAX          9'h0FF
`define TU_MIN          9'h001
`define TU_MAX          9'h0F0

// Reset values
`define RST_START       11'h001
`define RST_END         11'h020
`define RST_FD          8'h01
`define RST_TU          8'h0A

// Clock and times in their own units
`define CLK_KHZ         10000
`define TEACH_MIN_MS    20
`define TEACH_MAX_MS    80
`define CFG_TMO_MIN     5
`define BURN_MIN        15
`define SEC_PER_MIN     60

// Second counts derived from minutes
`define CFG_TMO_S       (`CFG_TMO_MIN * `SEC_PER_MIN)
`define BURN_S          (`BURN_MIN * `SEC_PER_MIN)
`define SEC_CNT_W       10

`endif

// >>> beam_io_pkg.sv
/*
 * Types for the beam area output block.
 * Assumes beam_io_params.svh for numbers.
 */
package beam_io_pkg;

    // Function of one digital pin
    typedef enum logic [2:0] {
        FN_TRIG_IN  = 3'h0,
        FN_TEACH_IN = 3'h1,
        FN_AREA_OUT = 3'h2,
        FN_WARN_OUT = 3'h3,
        FN_TRIG_OUT = 3'h4
    } io_func_t;

    // Display visibility setting
    typedef enum logic [2:0] {
        VIS_OFF     = 3'h0,
        VIS_DARK    = 3'h1,
        VIS_NORMAL  = 3'h2,
        VIS_BRIGHT  = 3'h3,
        VIS_DYNAMIC = 3'h4
    } vis_t;

    // Display lit state for the off setting
    typedef enum logic [1:0] {
        DS_LIT   = 2'b01,
        DS_BLANK = 2'b10
    } disp_state_t;

endpackage : beam_io_pkg

// >>> teach_pulse_detect.sv
/*
 * Flags a teach request when an active pulse lies inside the window.
 * Assumes a synchronised, polarity corrected input.
 */
`timescale 1ns/100ps
module teach_pulse_detect #(
    parameter int MIN_CYC = 200000,
    parameter int MAX_CYC = 800000
) (
    input  wire logic clk,      // System clock
    input  wire logic rstn,     // Async reset, active low
    input  wire logic enable,   // Pin set as teach input
    input  wire logic active,   // Line at its active level
    output logic      teach_o   // One-cycle teach request
);

    localparam logic [19:0] MIN_C = 20'(MIN_CYC);
    localparam logic [19:0] MAX_C = 20'(MAX_CYC);

    logic [19:0] width_q;
    logic        active_q;

    ////////////////////////////////////////////////////////////////////////
    // Saturating width counter; the compare against MAX_C rejects long pulses
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            width_q  <= 20'h00000;
            active_q <= 1'b0;
        end else begin
            active_q <= active & enable;
            if (!(active & enable)) begin
                width_q <= 20'h00000;
            end else if (width_q != 20'hFFFFF) begin
                width_q <= width_q + 20'h00001;
            end
        end
    end

    // Judge the pulse at its trailing edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            teach_o <= 1'b0;
        end else begin
            teach_o <= active_q && !(active & enable)
                       && (width_q > MIN_C) && (width_q < MAX_C);
        end
    end

endmodule : teach_pulse_detect

// >>> beam_area_switching_outputs.sv
/*
 * Beam area switching outputs: filtered beam evaluation,
 * per-pin area, warning, trigger and teach functions,
 * polarity, entry checks and display behaviour.
 * Assumes beam states and the tick come from logic on clk;
 * pins and the button are synchronised here.
 */
`timescale 1ns/100ps
`include "beam_io_params.svh"
module beam_area_switching_outputs #(
    parameter int SEC_CYCLES   = `CLK_KHZ * 1000,
    parameter int TEACH_MIN_CY = `TEACH_MIN_MS * `CLK_KHZ,
    parameter int TEACH_MAX_CY = `TEACH_MAX_MS * `CLK_KHZ
) (
    input  wire logic                      clk,          // System clock 10 MHz
    input  wire logic                      rstn,         // Async reset, low
    input  wire logic                      meas_tick,    // Measurement cycle strobe
    input  wire logic [`NUM_BEAMS-1:0]     beams_i,      // 1 = beam interrupted
    input  wire logic [`NUM_BEAMS-1:0]     active_i,     // 1 = beam not blanked
    input  wire logic                      warn_i,       // Warning condition
    input  wire logic                      trig_i,       // Trigger to send out
    input  wire logic                      cascade_en,   // Cascaded operation on
    input  wire logic                      pnp_sel,      // 1 sourcing, 0 sinking
    input  wire logic [`NUM_PINS-1:0]      pin_i,        // Pin levels read back
    output logic      [`NUM_PINS-1:0]      pin_o,        // Pin drive level
    output logic      [`NUM_PINS-1:0]      pin_oe_n,     // Low while driving
    output logic      [`NUM_PINS-1:0]      teach_req_o,  // Teach pulse seen
    output logic      [`NUM_PINS-1:0]      trig_in_o,    // Trigger input active
    input  wire logic                      cfg_wr,       // Pin configuration write
    input  wire logic [`PIN_IDX_W-1:0]     cfg_pin,      // Pin index
    input  wire beam_io_pkg::io_func_t     cfg_func,     // Pin function
    input  wire logic                      cfg_inv,      // Dark switching
    input  wire logic                      cfg_and,      // 1 AND, 0 OR
    input  wire logic [`BEAM_W-1:0]        cfg_start,    // Start beam
    input  wire logic [`BEAM_W-1:0]        cfg_end,      // End beam
    input  wire logic                      ht_exec,      // Height teach done
    input  wire logic [`PIN_IDX_W-1:0]     ht_pin,       // Pin of height teach
    input  wire logic [`BEAM_W-1:0]        ht_start,     // Taught start beam
    input  wire logic [`BEAM_W-1:0]        ht_end,       // Taught end beam
    input  wire logic                      fd_wr,        // Filter depth write
    input  wire logic [`ENTRY_W-1:0]       fd_val,       // Filter depth entry
    input  wire logic                      tu_wr,        // Darkening time write
    input  wire logic [`ENTRY_W-1:0]       tu_val,       // Darkening time, s
    input  wire beam_io_pkg::vis_t         vis_sel,      // Visibility setting
    input  wire logic                      button_i,     // Panel button pin
    output logic                           cfg_ack_o,    // Entry accepted
    output logic                           cfg_rej_o,    // Entry rejected
    output logic [1:0]                     disp_level_o, // 0 off .. 3 bright
    output logic                           disp_inv_o,   // Display inverted
    output logic                           cfg_mode_o    // Configuration mode
);
    import beam_io_pkg::*;

    localparam logic [23:0] SEC_C = 24'(SEC_CYCLES - 1);
    localparam logic [`SEC_CNT_W-1:0] CFG_TMO = `SEC_CNT_W'(`CFG_TMO_S);
    localparam logic [`SEC_CNT_W-1:0] BURN_T  = `SEC_CNT_W'(`BURN_S);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and button
    logic [`NUM_PINS-1:0] pin_s1_q, pin_s2_q;
    logic                 btn_s1_q, btn_s2_q, btn_d_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            btn_s1_q <= 1'b0;
            btn_s2_q <= 1'b0;
            btn_d_q  <= 1'b0;
        end else begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
            btn_s1_q <= button_i;
            btn_s2_q <= btn_s1_q;
            btn_d_q  <= btn_s2_q;
        end
    end

    wire btn_press = btn_s2_q & ~btn_d_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration store with range checks
    io_func_t           func_q  [`NUM_PINS];
    logic               inv_q   [`NUM_PINS];
    logic               and_q   [`NUM_PINS];
    logic [`BEAM_W-1:0] start_q [`NUM_PINS];
    logic [`BEAM_W-1:0] end_q   [`NUM_PINS];
    logic [7:0]         fd_q;
    logic [7:0]         tu_q;

    // Beam zero does not exist and is refused
    wire cfg_ok = (cfg_start >= `BEAM_MIN) && (cfg_start <= `BEAM_MAX)
               && (cfg_end <= `BEAM_MAX) && (cfg_end >= cfg_start);
    wire ht_ok  = (ht_start >= `BEAM_MIN) && (ht_start <= `BEAM_MAX)
               && (ht_end <= `BEAM_MAX) && (ht_end >= ht_start);
    wire fd_ok  = (fd_val <= `FD_MAX);
    wire tu_ok  = (tu_val >= `TU_MIN) && (tu_val <= `TU_MAX);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int p = 0; p < `NUM_PINS; p++) begin
                func_q[p]  <= FN_AREA_OUT;
                inv_q[p]   <= 1'b0;
                and_q[p]   <= 1'b0;
                start_q[p] <= `RST_START;
                end_q[p]   <= `RST_END;
            end
        end else begin
            if (cfg_wr) begin
                func_q[cfg_pin] <= cfg_func;
                inv_q[cfg_pin]  <= cfg_inv;
                and_q[cfg_pin]  <= cfg_and;
                if (cfg_ok) begin
                    start_q[cfg_pin] <= cfg_start;
                    end_q[cfg_pin]   <= cfg_end;
                end
            end
            // Teach wins over a write to the same pin
            if (ht_exec && ht_ok) begin
                start_q[ht_pin] <= ht_start;
                end_q[ht_pin]   <= ht_end;
            end
        end
    end

    // Global settings; a refused entry keeps the old value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fd_q <= `RST_FD;
            tu_q <= `RST_TU;
        end else begin
            if (fd_wr && fd_ok) fd_q <= fd_val[7:0];
            if (tu_wr && tu_ok) tu_q <= tu_val[7:0];
        end
    end

    // Accept or refuse answer, one cycle after the write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ack_o <= 1'b0;
            cfg_rej_o <= 1'b0;
        end else begin
            cfg_rej_o <= (cfg_wr & ~cfg_ok) | (ht_exec & ~ht_ok)
                       | (fd_wr & ~fd_ok) | (tu_wr & ~tu_ok);
            cfg_ack_o <= (cfg_wr & cfg_ok) | (ht_exec & ht_ok)
                       | (fd_wr & fd_ok) | (tu_wr & tu_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stability filter: only settled beam states are evaluated
    logic [`NUM_BEAMS-1:0] snap_q, eval_q;
    logic [7:0]            same_q;
    logic [7:0]            same_d;

    // Depth zero behaves as one so evaluation never stalls
    wire [7:0] depth_eff = (fd_q == 8'h00) ? 8'h01 : fd_q;

    always_comb begin
        same_d = 8'h01;
        if (beams_i == snap_q) begin
            same_d = (same_q == 8'hFF) ? 8'hFF : same_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap_q <= '0;
            eval_q <= '0;
            same_q <= 8'h00;
        end else if (meas_tick) begin
            snap_q <= beams_i;
            same_q <= same_d;
            if (same_d >= depth_eff) eval_q <= beams_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin area evaluation, function select, inversion and polarity
    for (genvar p = 0; p < `NUM_PINS; p++) begin : g_pin
        logic [`NUM_BEAMS-1:0] in_rng;
        logic                  area;
        logic                  lvl;
        logic                  drive;
        wire                   pin_act = pnp_sel ? pin_s2_q[p] : ~pin_s2_q[p];

        for (genvar b = 0; b < `NUM_BEAMS; b++) begin : g_beam
            assign in_rng[b] = (`BEAM_W'(b + 1) >= start_q[p])
                             && (`BEAM_W'(b + 1) <= end_q[p]);
        end

        wire [`NUM_BEAMS-1:0] watch = in_rng & active_i;
        wire any_cut = |(watch & eval_q);
        wire all_cut = (|watch) && ((watch & ~eval_q) == '0);

        // Outputs pass through inversion; inputs and idle triggers float
        always_comb begin
            area  = and_q[p] ? all_cut : any_cut;
            lvl   = 1'b0;
            drive = 1'b0;
            case (func_q[p])
                FN_AREA_OUT: begin
                    lvl   = area;
                    drive = 1'b1;
                end
                FN_WARN_OUT: begin
                    lvl   = warn_i;
                    drive = 1'b1;
                end
                FN_TRIG_OUT: begin
                    lvl   = trig_i;
                    drive = cascade_en;
                end
                default: begin
                    lvl   = 1'b0;
                    drive = 1'b0;
                end
            endcase
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pin_o[p]     <= 1'b0;
                pin_oe_n[p]  <= 1'b1;
                trig_in_o[p] <= 1'b0;
            end else begin
                pin_o[p]     <= pnp_sel ? (lvl ^ inv_q[p])
                                        : ~(lvl ^ inv_q[p]);
                pin_oe_n[p]  <= ~drive;
                trig_in_o[p] <= pin_act && cascade_en
                                && (func_q[p] == FN_TRIG_IN);
            end
        end

        teach_pulse_detect #(
            .MIN_CYC (TEACH_MIN_CY),
            .MAX_CYC (TEACH_MAX_CY)
        ) u_teach (
            .clk     (clk),
            .rstn    (rstn),
            .enable  (func_q[p] == FN_TEACH_IN),
            .active  (pin_act),
            .teach_o (teach_req_o[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // One-second enable from a divider; seconds are coarse enough here
    logic [23:0] div_q;
    logic        sec_tick;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q    <= 24'h000000;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= (div_q == SEC_C);
            div_q    <= (div_q == SEC_C) ? 24'h000000 : div_q + 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration mode and its idle timeout
    logic [`SEC_CNT_W-1:0] idle_q;
    wire cfg_tmo = sec_tick && (idle_q == CFG_TMO - `SEC_CNT_W'(1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_q     <= '0;
            cfg_mode_o <= 1'b0;
        end else begin
            // A press in the timeout cycle keeps the mode open
            if (btn_press) begin
                idle_q     <= '0;
                cfg_mode_o <= 1'b1;
            end else if (cfg_tmo) begin
                idle_q     <= '0;
                cfg_mode_o <= 1'b0;
            end else if (sec_tick && cfg_mode_o) begin
                idle_q <= idle_q + `SEC_CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lit state for the off setting: only a press lights the display
    disp_state_t ds_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ds_q <= DS_BLANK;
        end else begin
            case (ds_q)
                DS_BLANK: if (btn_press) ds_q <= DS_LIT;
                DS_LIT:   if (cfg_tmo && !btn_press) ds_q <= DS_BLANK;
                default:  ds_q <= DS_BLANK;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dynamic darkening and burn-in inversion timers
    logic [7:0]            dyn_q;
    logic [`SEC_CNT_W-1:0] burn_q;
    wire static_lvl = (vis_sel == VIS_DARK) || (vis_sel == VIS_NORMAL)
                   || (vis_sel == VIS_BRIGHT);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dyn_q <= 8'h00;
        end else if (btn_press || vis_sel != VIS_DYNAMIC) begin
            dyn_q <= 8'h00;
        end else if (sec_tick && dyn_q < tu_q) begin
            dyn_q <= dyn_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burn_q     <= '0;
            disp_inv_o <= 1'b0;
        end else if (!static_lvl) begin
            burn_q     <= '0;
            disp_inv_o <= 1'b0;
        end else if (sec_tick) begin
            if (burn_q == BURN_T - `SEC_CNT_W'(1)) begin
                burn_q     <= '0;
                disp_inv_o <= ~disp_inv_o;
            end else begin
                burn_q <= burn_q + `SEC_CNT_W'(1);
            end
        end
    end

    // Brightness; dynamic splits the span into thirds
    wire [9:0] dyn3 = {2'b00, dyn_q} * 10'h003;
    wire [9:0] tu1  = {2'b00, tu_q};
    wire [9:0] tu2  = {1'b0, tu_q, 1'b0};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disp_level_o <= 2'h0;
        end else begin
            case (vis_sel)
                VIS_OFF:     disp_level_o <= (ds_q == DS_LIT) ? 2'h2 : 2'h0;
                VIS_DARK:    disp_level_o <= 2'h1;
                VIS_NORMAL:  disp_level_o <= 2'h2;
                VIS_BRIGHT:  disp_level_o <= 2'h3;
                VIS_DYNAMIC: begin
                    if (dyn_q >= tu_q)      disp_level_o <= 2'h0;
                    else if (dyn3 >= tu2)   disp_level_o <= 2'h1;
                    else if (dyn3 >= tu1)   disp_level_o <= 2'h2;
                    else                    disp_level_o <= 2'h3;
                end
                default:     disp_level_o <= 2'h2;
            endcase
        end
    end

endmodule : beam_area_switching_outputs

// >>> beam_area_properties.sv
/* Checker on the block's ports. Assumes one clock, active-low reset. */
`timescale 1ns/100ps
`include "beam_io_params.svh"
module beam_area_properties (
    input wire logic        clk,          // Clock
    input wire logic        rstn,         // Reset, low
    input wire logic        cfg_wr,       // Pin write
    input wire logic [10:0] cfg_start,    // Start beam
    input wire logic [10:0] cfg_end,      // End beam
    input wire logic        fd_wr,        // Depth write
    input wire logic [8:0]  fd_val,       // Depth entry
    input wire logic        tu_wr,        // Time write
    input wire logic [8:0]  tu_val,       // Time entry
    input wire logic        cascade_en,   // Cascading on
    input wire logic [3:0]  trig_in_o,    // Trigger inputs
    input wire logic [2:0]  vis_sel,      // Visibility
    input wire logic        cfg_ack_o,    // Accepted
    input wire logic        cfg_rej_o,    // Refused
    input wire logic [1:0]  disp_level_o, // Brightness
    input wire logic        disp_inv_o,   // Inverted
    input wire logic        cfg_mode_o    // Config mode
);
    import beam_io_pkg::*;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    // Pin, depth and time entries are answered on the cycle after their strobe
    a_start_over: assert property (cfg_wr && cfg_start > `BEAM_MAX |=> cfg_rej_o)
        else $error("start beam taken");
    a_end_below: assert property (cfg_wr && cfg_end < cfg_start |=> cfg_rej_o)
        else $error("reversed range taken");
    a_depth_over: assert property (fd_wr && fd_val > `FD_MAX |=> cfg_rej_o)
        else $error("bad depth taken");
    a_depth_ok: assert property (fd_wr && fd_val <= `FD_MAX |=> cfg_ack_o)
        else $error("good depth refused");
    a_time_bad: assert property (tu_wr && (tu_val < `TU_MIN || tu_val > `TU_MAX)
        |=> cfg_rej_o) else $error("bad time taken");
    a_time_ok: assert property (tu_wr && tu_val inside {[`TU_MIN:`TU_MAX]} |=> cfg_ack_o)
        else $error("good time refused");
    // Trigger inputs lag cascading by one flop
    a_trig_gated: assert property (trig_in_o != 4'h0 |-> $past(cascade_en))
        else $error("trigger without cascading");
    // Off display lit only near configuration mode
    a_off_dark: assert property ((vis_sel == VIS_OFF)[*3] ##0 disp_level_o != 2'h0
        |-> ##[0:2] cfg_mode_o or $past(cfg_mode_o, 2)) else $error("off display lit");
    a_inv_cleared: assert property ((vis_sel == VIS_OFF || vis_sel == VIS_DYNAMIC)[*2]
        |-> !disp_inv_o) else $error("inversion kept");
    c_refused: cover property (cfg_rej_o);
    c_inverted: cover property (disp_inv_o);
    c_timeout: cover property ($fell(cfg_mode_o));
endmodule : beam_area_properties

bind beam_area_switching_outputs beam_area_properties u_beam_area_properties (.*);

// >>> plc_model.sv
/* Controller on the pins: resolves each wire, drives teach and trigger
   levels. Assumes tasks are called at a falling edge. */
`timescale 1ns/100ps
module plc_model (
    input wire logic       clk,      // Clock
    input wire logic       pnp_sel,  // 1 sourcing
    input wire logic [3:0] pin_o,    // Device level
    input wire logic [3:0] pin_oe_n, // Low drives
    output logic     [3:0] pin_i     // Wire level
);
    logic [3:0] act = 4'h0; // Lines held active

    // Released lines fall to the inactive level through the load
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            pin_i[p] = !pin_oe_n[p] ? pin_o[p] : (act[p] ~^ pnp_sel);
        end
    end

    // Active pulse of n clocks
    task automatic pulse(input int p, input int n);
        act[p] = 1'b1;
        repeat (n) @(negedge clk);
        act[p] = 1'b0;
    endtask : pulse

    // Steady level for trigger inputs
    task automatic hold(input int p, input logic v);
        act[p] = v;
    endtask : hold
endmodule : plc_model

// >>> tb_top.sv
/* Bench: area table, then range, entry, filter, polarity, trigger,
   teach and display tests. Assumes plc_model. */
`timescale 1ns/100ps
module tb_top;
    import beam_io_pkg::*;
    typedef struct {logic a, i; logic [10:0] e; logic [63:0] b; logic x;} row_t;
    logic clk, rstn, meas_tick, warn_i, trig_i, cascade_en, pnp_sel, cfg_wr, cfg_inv;
    logic cfg_and, ht_exec, fd_wr, tu_wr, button_i, cfg_ack_o, cfg_rej_o, disp_inv_o;
    logic cfg_mode_o;
    logic [1773:0] beams_i, active_i;
    logic [3:0]    pin_i, pin_o, pin_oe_n, teach_req_o, trig_in_o, seen;
    logic [1:0]    cfg_pin, ht_pin, disp_level_o, r;
    logic [10:0]   cfg_start, cfg_end, ht_start, ht_end;
    logic [8:0]    fd_val, tu_val;
    io_func_t      cfg_func;
    vis_t          vis_sel;
    int            fail_count, cmp_count, cycles;
    logic [8:0]    ev[7] = '{9'h100, 9'h0FF, 9'h005, 9'h000, 9'h0F1, 9'h0F0, 9'h003};
    int            tw[3] = '{10, 50, 90};
    row_t rows[7] = '{'{1'b0, 1'b0, 11'h020, 64'h0, 1'b0},
        '{1'b0, 1'b0, 11'h020, 64'h1, 1'b1},
        '{1'b0, 1'b0, 11'h020, 64'h100000000, 1'b0},
        '{1'b0, 1'b1, 11'h020, 64'h80000000, 1'b0},
        '{1'b1, 1'b0, 11'h004, 64'h7, 1'b0},
        '{1'b1, 1'b0, 11'h004, 64'hF, 1'b1},
        '{1'b1, 1'b1, 11'h004, 64'hF, 1'b0}};

    beam_area_switching_outputs #(.SEC_CYCLES(10), .TEACH_MIN_CY(20), .TEACH_MAX_CY(80))
        u_beam_area_switching_outputs (.*);
    plc_model u_plc_model (.*);
    ////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Ceiling above the longest wait
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle strobe; either answer is caught across two cycles
    task automatic wr(input logic [3:0] s);
        {tu_wr, fd_wr, ht_exec, cfg_wr} = s;
        @(negedge clk);
        {tu_wr, fd_wr, ht_exec, cfg_wr} = 4'h0;
        r = {cfg_rej_o, cfg_ack_o};
        @(negedge clk);
        r = r | {cfg_rej_o, cfg_ack_o};
    endtask : wr

    task automatic pcfg(input logic [1:0] p, input io_func_t f, input logic a, i,
                        input logic [10:0] s, e);
        {cfg_pin, cfg_func, cfg_and, cfg_inv, cfg_start, cfg_end} = {p, f, a, i, s, e};
        wr(4'h1);
    endtask : pcfg

    task automatic tick(input int n);
        repeat (n) begin
            meas_tick = 1'b1;
            @(negedge clk);
            meas_tick = 1'b0;
            @(negedge clk);
        end
    endtask : tick

    task automatic done(input string s);
        $display("test %s done, mismatches %0d", s, fail_count);
    endtask : done

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        {rstn, meas_tick, warn_i, trig_i, cascade_en, button_i} = '0;
        {tu_wr, fd_wr, ht_exec, cfg_wr, cfg_inv, cfg_and, pnp_sel} = 7'h01;
        {cfg_pin, ht_pin, cfg_start, cfg_end, ht_start, ht_end, fd_val, tu_val} = '0;
        {beams_i, active_i} = {1774'h0, {1774{1'b1}}};
        cfg_func = FN_AREA_OUT;
        vis_sel = VIS_OFF;
        repeat (3) @(negedge clk);
        chk({pin_oe_n, disp_level_o, cfg_mode_o}, 7'h78);
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        foreach (rows[k]) begin
            pcfg(2'h0, FN_AREA_OUT, rows[k].a, rows[k].i, 11'h001, rows[k].e);
            beams_i = '0;
            beams_i[63:0] = rows[k].b;
            tick(1);
            chk({pin_oe_n[0], pin_o[0]}, {1'b0, rows[k].x});
        end
        done("rows");
        pcfg(2'h0, FN_AREA_OUT, 1'b0, 1'b0, 11'h6EF, 11'h6EF);
        chk(r, 2'h2);
        pcfg(2'h0, FN_AREA_OUT, 1'b0, 1'b0, 11'h6EE, 11'h6EE);
        chk(r, 2'h1);
        pcfg(2'h0, FN_AREA_OUT, 1'b0, 1'b0, 11'h010, 11'h00F);
        chk(r, 2'h2);
        beams_i = '0;
        beams_i[1773] = 1'b1;
        tick(1);
        chk(pin_o[0], 1'b1);
        {ht_pin, ht_start, ht_end} = {2'h0, 11'h064, 11'h064};
        wr(4'h2);
        chk(r, 2'h1);
        beams_i = '0;
        beams_i[99] = 1'b1;
        tick(1);
        chk(pin_o[0], 1'b1);
        done("range");
        for (int k = 0; k < 7; k++) begin
            {fd_val, tu_val} = {ev[k], ev[k]};
            wr(k < 3 ? 4'h4 : 4'h8);
            chk(r, (k == 0 || k == 3 || k == 4) ? 2'h2 : 2'h1);
        end
        beams_i = '0;
        tick(4);
        chk(pin_o[0], 1'b1);
        tick(1);
        chk(pin_o[0], 1'b0);
        pnp_sel = 1'b0;
        repeat (3) @(negedge clk);
        chk(pin_o[0], 1'b1);
        pnp_sel = 1'b1;
        done("entries");
        pcfg(2'h1, FN_TRIG_IN, 1'b0, 1'b0, 11'h001, 11'h001);
        pcfg(2'h2, FN_TRIG_OUT, 1'b0, 1'b0, 11'h001, 11'h001);
        {trig_i, warn_i} = 2'h3;
        u_plc_model.hold(1, 1'b1);
        repeat (5) @(negedge clk);
        chk({trig_in_o[1], pin_oe_n[2]}, 2'h1);
        cascade_en = 1'b1;
        repeat (5) @(negedge clk);
        chk({trig_in_o[1], pin_oe_n[2], pin_o[2]}, 3'h5);
        u_plc_model.hold(1, 1'b0);
        pcfg(2'h2, FN_WARN_OUT, 1'b0, 1'b1, 11'h001, 11'h001);
        chk({pin_oe_n[2], pin_o[2]}, 2'h0);
        done("trigger");
        pcfg(2'h3, FN_TEACH_IN, 1'b0, 1'b0, 11'h001, 11'h001);
        for (int k = 0; k < 3; k++) begin
            seen = 4'h0;
            u_plc_model.pulse(3, tw[k]);
            repeat (10) begin
                @(negedge clk);
                seen[0] = seen[0] | teach_req_o[3];
            end
            chk(seen[0], k == 1);
        end
        done("teach");
        chk(disp_level_o, 2'h0);
        button_i = 1'b1;
        @(negedge clk);
        button_i = 1'b0;
        repeat (6) @(negedge clk);
        chk({cfg_mode_o, disp_level_o}, 3'h6);
        repeat (2890) @(negedge clk);
        chk(cfg_mode_o, 1'b1);
        repeat (200) @(negedge clk);
        chk({cfg_mode_o, disp_level_o}, 3'h0);
        vis_sel = VIS_DYNAMIC;
        button_i = 1'b1;
        @(negedge clk);
        button_i = 1'b0;
        seen = 4'h0;
        repeat (60) begin
            @(negedge clk);
            seen = seen | (4'h1 << disp_level_o);
        end
        chk({seen, disp_level_o}, 6'h3C);
        vis_sel = VIS_NORMAL;
        seen = 4'h0;
        repeat (9100) begin
            @(negedge clk);
            seen[0] = seen[0] | disp_inv_o;
        end
        chk({seen[0], disp_level_o}, 3'h6);
        done("display");
        summarize();
    end
endmodule : tb_top
